/* src/cpg_top.sv */
// Notes on behaviour
// - Steered outputs carry waveform, others static level
// - Steered mode applies steering the next cycle
// - Synchronous steered mode: steering waits for rise
// - Full bridge: one modulated, one fully on
// - Direction change delays modulated output by dead-band
// - Forward: D modulated, A held on
// - Reverse: B modulated, C held on
// - Half bridge makes primary and complementary pair
// - Primary to A/C, complementary to B/D
// - Half-bridge dead time leaves both outputs off
// - Push-pull alternates A/C and B/D pairs
// - Rise starts drive and swaps pair; fall ends
// - Blanking masks opposite event inputs after drive
// - Phase delay postpones drive after rising event
// - All timers count on the timing clock
// - Two-bit select picks oscillator, instruction, system clock
// - Enabled sources of each kind are ORed
// - Per-source sense: set edge, clear level
// - Zero delays start the primary at once
// - Rise: phase, clear complementary, blank, dead-band, primary
// - Fall: phase, clear primary, blank, dead-band, complementary
// - Disabled: primary inactive, complementary active
//
// Our own choices: the Wishbone register port and the register offsets.
module cpg_top #(
    parameter int N_SRC = 8,
    parameter int TW = 8
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Event sources
    input wire logic [N_SRC-1:0] rise_src_i,
    input wire logic [N_SRC-1:0] fall_src_i,
    // Drive outputs
    output logic drive_out_a_o,
    output logic drive_out_b_o,
    output logic drive_out_c_o,
    output logic drive_out_d_o
);
    typedef enum logic [5:0] {
        ST_COMP = 6'h01,
        ST_RPH = 6'h02,
        ST_RDB = 6'h04,
        ST_ON = 6'h08,
        ST_FPH = 6'h10,
        ST_FDB = 6'h20
    } cpg_state_t;

    if (TW < 1 || TW > 8) begin : g_chk
        $error("TW must lie in 1..8");
    end

    logic en_r;
    logic [2:0] mode_r;
    logic [1:0] cs_r;
    logic [3:0] steer_r, static_r, steer_act_r;
    logic steer_pend_r;
    logic [N_SRC-1:0] rsrc_en_r, rsense_r, fsrc_en_r, fsense_r;
    logic [TW-1:0] rph_r, fph_r, rdb_r, fdb_r, rblk_r, fblk_r;
    logic [TW-1:0] cnt_r, cnt_nxt, rblk_cnt_r, fblk_cnt_r, fb_hold_r;
    logic [TW-1:0] rdb_eff, fdb_eff;
    localparam int DIV_W_L = cpg_pkg::DIV_W;
    logic [DIV_W_L-1:0] div_r;
    logic tick_r;
    logic rise_sig, fall_sig, rise_prev_r, fall_prev_r;
    logic rise_go, fall_go, do_rise, do_fall, rdone, fdone;
    logic rblk_go, fblk_go;
    cpg_state_t st_r, st_nxt;
    logic prim_r, comp_r, prim_nxt, comp_nxt;
    logic pp_sel_r, fb_dir_r, fb_dir_nxt, fb_mode;
    logic [3:0] wave, out_nxt;
    logic wb_req, wb_wr, wr_steer;
    logic [31:0] rd_nxt;

    // Bus request; ack one cycle later, write lands on the edge the master sees ack
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    assign wr_steer = wb_wr & (wb_adr_i == cpg_pkg::ADR_STEER) & wb_sel_i[0];

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_nxt : wb_dat_o;
        end
    end

    // Register writes, byte lane per field group
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            en_r <= 1'b0;
            mode_r <= cpg_pkg::MODE_RST;
            cs_r <= cpg_pkg::CS_RST;
            steer_r <= cpg_pkg::STEER_RST;
            static_r <= cpg_pkg::STEER_RST;
            rsrc_en_r <= '0;
            rsense_r <= '0;
            fsrc_en_r <= '0;
            fsense_r <= '0;
            {rph_r, fph_r, rdb_r, fdb_r, rblk_r, fblk_r} <= '0;
        end else if (wb_wr) begin
            unique case (wb_adr_i)
                cpg_pkg::ADR_CTRL: if (wb_sel_i[0]) begin
                    en_r <= wb_dat_i[cpg_pkg::CTRL_EN];
                    mode_r <= wb_dat_i[cpg_pkg::CTRL_MODE +: 3];
                    cs_r <= wb_dat_i[cpg_pkg::CTRL_CS +: 2];
                end
                cpg_pkg::ADR_STEER: if (wb_sel_i[0]) begin
                    steer_r <= wb_dat_i[cpg_pkg::STEER_EN +: 4];
                    static_r <= wb_dat_i[cpg_pkg::STEER_LVL +: 4];
                end
                cpg_pkg::ADR_RSRC: begin
                    if (wb_sel_i[0]) rsrc_en_r <= wb_dat_i[cpg_pkg::LANE0 +: N_SRC];
                    if (wb_sel_i[1]) rsense_r <= wb_dat_i[cpg_pkg::LANE1 +: N_SRC];
                end
                cpg_pkg::ADR_FSRC: begin
                    if (wb_sel_i[0]) fsrc_en_r <= wb_dat_i[cpg_pkg::LANE0 +: N_SRC];
                    if (wb_sel_i[1]) fsense_r <= wb_dat_i[cpg_pkg::LANE1 +: N_SRC];
                end
                cpg_pkg::ADR_PHASE: begin
                    if (wb_sel_i[0]) rph_r <= wb_dat_i[cpg_pkg::LANE0 +: TW];
                    if (wb_sel_i[1]) fph_r <= wb_dat_i[cpg_pkg::LANE1 +: TW];
                end
                cpg_pkg::ADR_DBAND: begin
                    if (wb_sel_i[0]) rdb_r <= wb_dat_i[cpg_pkg::LANE0 +: TW];
                    if (wb_sel_i[1]) fdb_r <= wb_dat_i[cpg_pkg::LANE1 +: TW];
                end
                cpg_pkg::ADR_BLANK: begin
                    if (wb_sel_i[0]) rblk_r <= wb_dat_i[cpg_pkg::LANE0 +: TW];
                    if (wb_sel_i[1]) fblk_r <= wb_dat_i[cpg_pkg::LANE1 +: TW];
                end
                default: ; // Status and unmapped writes are dropped
            endcase
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_nxt = '0;
        unique case (wb_adr_i)
            cpg_pkg::ADR_CTRL: begin
                rd_nxt[cpg_pkg::CTRL_EN] = en_r;
                rd_nxt[cpg_pkg::CTRL_MODE +: 3] = mode_r;
                rd_nxt[cpg_pkg::CTRL_CS +: 2] = cs_r;
            end
            cpg_pkg::ADR_STEER: begin
                rd_nxt[cpg_pkg::STEER_EN +: 4] = steer_r;
                rd_nxt[cpg_pkg::STEER_LVL +: 4] = static_r;
            end
            cpg_pkg::ADR_RSRC: begin
                rd_nxt[cpg_pkg::LANE0 +: N_SRC] = rsrc_en_r;
                rd_nxt[cpg_pkg::LANE1 +: N_SRC] = rsense_r;
            end
            cpg_pkg::ADR_FSRC: begin
                rd_nxt[cpg_pkg::LANE0 +: N_SRC] = fsrc_en_r;
                rd_nxt[cpg_pkg::LANE1 +: N_SRC] = fsense_r;
            end
            cpg_pkg::ADR_PHASE: begin
                rd_nxt[cpg_pkg::LANE0 +: TW] = rph_r;
                rd_nxt[cpg_pkg::LANE1 +: TW] = fph_r;
            end
            cpg_pkg::ADR_DBAND: begin
                rd_nxt[cpg_pkg::LANE0 +: TW] = rdb_r;
                rd_nxt[cpg_pkg::LANE1 +: TW] = fdb_r;
            end
            cpg_pkg::ADR_BLANK: begin
                rd_nxt[cpg_pkg::LANE0 +: TW] = rblk_r;
                rd_nxt[cpg_pkg::LANE1 +: TW] = fblk_r;
            end
            cpg_pkg::ADR_STAT: begin
                rd_nxt[3:0] = {drive_out_d_o, drive_out_c_o, drive_out_b_o, drive_out_a_o};
                rd_nxt[cpg_pkg::STAT_PRIM] = prim_r;
                rd_nxt[cpg_pkg::STAT_COMP] = comp_r;
                rd_nxt[cpg_pkg::STAT_DIR] = fb_dir_r;
            end
            default: ;
        endcase
    end

    // Timing clock enable; oscillator rate is approximated by whole divide
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            div_r <= '0;
            tick_r <= 1'b0;
        end else if (cs_r == cpg_pkg::CS_SYS) begin
            div_r <= '0;
            tick_r <= 1'b1;
        end else if (div_r >= ((cs_r == cpg_pkg::CS_INSN) ? cpg_pkg::INSN_DIV
                                                           : cpg_pkg::OSC_DIV) - 1'b1) begin
            div_r <= '0;
            tick_r <= 1'b1;
        end else begin
            div_r <= div_r + 1'b1;
            tick_r <= 1'b0;
        end
    end

    // Event conditioning per direction
    cpg_evt_cond #(.N_SRC(N_SRC)) u_rise (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .src_i(rise_src_i),
        .enable_i(rsrc_en_r),
        .sense_i(rsense_r),
        .comb_o(rise_sig)
    );
    cpg_evt_cond #(.N_SRC(N_SRC)) u_fall (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .src_i(fall_src_i),
        .enable_i(fsrc_en_r),
        .sense_i(fsense_r),
        .comb_o(fall_sig)
    );

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rise_prev_r <= 1'b0;
            fall_prev_r <= 1'b0;
        end else begin
            rise_prev_r <= rise_sig;
            fall_prev_r <= fall_sig;
        end
    end

    // Events are low-to-high transitions, masked by opposite blanking
    assign rise_go = en_r & rise_sig & ~rise_prev_r & (fblk_cnt_r == '0);
    assign fall_go = en_r & fall_sig & ~fall_prev_r & (rblk_cnt_r == '0);
    assign do_rise = rise_go & (st_r inside {ST_COMP, ST_FPH, ST_FDB});
    assign do_fall = fall_go & (st_r inside {ST_RPH, ST_RDB, ST_ON});

    // Sequencer dead time only shapes half-bridge edges
    assign rdb_eff = (mode_r == cpg_pkg::MD_HALF) ? rdb_r : '0;
    assign fdb_eff = (mode_r == cpg_pkg::MD_HALF) ? fdb_r : '0;

    // Event sequencer; an opposite event aborts the sequence in progress
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = (tick_r && cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
        prim_nxt = prim_r;
        comp_nxt = comp_r;
        rblk_go = 1'b0;
        fblk_go = 1'b0;
        rdone = 1'b0;
        fdone = 1'b0;
        if (do_rise) begin
            if (rph_r != '0) begin
                st_nxt = ST_RPH;
                cnt_nxt = rph_r;
            end else begin
                rdone = 1'b1;
            end
        end else if (do_fall) begin
            if (fph_r != '0) begin
                st_nxt = ST_FPH;
                cnt_nxt = fph_r;
            end else begin
                fdone = 1'b1;
            end
        end else begin
            unique case (st_r)
                ST_RPH: rdone = (cnt_r == '0);
                ST_FPH: fdone = (cnt_r == '0);
                ST_RDB: if (cnt_r == '0) begin
                    prim_nxt = 1'b1;
                    st_nxt = ST_ON;
                end
                ST_FDB: if (cnt_r == '0) begin
                    comp_nxt = 1'b1;
                    st_nxt = ST_COMP;
                end
                ST_COMP, ST_ON: ;
            endcase
        end
        if (rdone) begin
            comp_nxt = 1'b0;
            rblk_go = 1'b1;
            if (rdb_eff != '0) begin
                st_nxt = ST_RDB;
                cnt_nxt = rdb_eff;
            end else begin
                prim_nxt = 1'b1;
                st_nxt = ST_ON;
            end
        end
        if (fdone) begin
            prim_nxt = 1'b0;
            fblk_go = 1'b1;
            if (fdb_eff != '0) begin
                st_nxt = ST_FDB;
                cnt_nxt = fdb_eff;
            end else begin
                comp_nxt = 1'b1;
                st_nxt = ST_COMP;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i || !en_r) begin
            st_r <= ST_COMP;
            cnt_r <= '0;
            prim_r <= 1'b0;
            comp_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            prim_r <= prim_nxt;
            comp_r <= comp_nxt;
        end
    end

    // Blanking counters; rise blanks falling inputs and vice versa
    always_ff @(posedge mclk_i) begin
        if (reset_i || !en_r) begin
            rblk_cnt_r <= '0;
            fblk_cnt_r <= '0;
        end else begin
            if (rblk_go) rblk_cnt_r <= rblk_r;
            else if (tick_r && rblk_cnt_r != '0) rblk_cnt_r <= rblk_cnt_r - 1'b1;
            if (fblk_go) fblk_cnt_r <= fblk_r;
            else if (tick_r && fblk_cnt_r != '0) fblk_cnt_r <= fblk_cnt_r - 1'b1;
        end
    end

    // Push-pull pair select flips on each accepted rise
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pp_sel_r <= 1'b0;
        end else if (do_rise && mode_r == cpg_pkg::MD_PP) begin
            pp_sel_r <= ~pp_sel_r;
        end
    end

    // Full-bridge direction; modulated leg held off for the dead time
    assign fb_mode = (mode_r == cpg_pkg::MD_FWD) || (mode_r == cpg_pkg::MD_REV);
    assign fb_dir_nxt = (mode_r == cpg_pkg::MD_REV);
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            fb_dir_r <= 1'b0;
            fb_hold_r <= '0;
        end else if (fb_mode && fb_dir_nxt != fb_dir_r) begin
            fb_dir_r <= fb_dir_nxt;
            fb_hold_r <= fb_dir_nxt ? fdb_r : rdb_r;
        end else if (tick_r && fb_hold_r != '0) begin
            fb_hold_r <= fb_hold_r - 1'b1;
        end
    end

    // Steering; synchronous mode defers to the next rise
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            steer_act_r <= cpg_pkg::STEER_RST;
            steer_pend_r <= 1'b0;
        end else begin
            if (wr_steer) steer_pend_r <= 1'b1; // Set wins over clear
            else if (do_rise) steer_pend_r <= 1'b0;
            if (mode_r != cpg_pkg::MD_SSTEER) steer_act_r <= steer_r;
            else if (do_rise && steer_pend_r) steer_act_r <= steer_r;
        end
    end

    // Per-mode waveform, bit order D C B A
    always_comb begin
        wave = '0;
        if (!en_r) begin
            wave = (mode_r == cpg_pkg::MD_HALF) ? cpg_pkg::HB_COMP_MASK : '0;
        end else begin
            unique case (mode_r)
                cpg_pkg::MD_STEER, cpg_pkg::MD_SSTEER: wave = {4{prim_r}};
                cpg_pkg::MD_FWD, cpg_pkg::MD_REV: begin
                    wave[0] = ~fb_dir_r;
                    wave[3] = ~fb_dir_r & prim_r & (fb_hold_r == '0);
                    wave[2] = fb_dir_r;
                    wave[1] = fb_dir_r & prim_r & (fb_hold_r == '0);
                end
                cpg_pkg::MD_HALF: wave = {comp_r, prim_r, comp_r, prim_r};
                cpg_pkg::MD_PP: begin
                    wave[0] = prim_r & ~pp_sel_r;
                    wave[2] = prim_r & ~pp_sel_r;
                    wave[1] = prim_r & pp_sel_r;
                    wave[3] = prim_r & pp_sel_r;
                end
                default: wave = '0;
            endcase
        end
    end

    // Unsteered outputs show their static level
    assign out_nxt = (steer_act_r & wave) | (~steer_act_r & static_r);

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            {drive_out_d_o, drive_out_c_o, drive_out_b_o, drive_out_a_o} <= '0;
        end else begin
            {drive_out_d_o, drive_out_c_o, drive_out_b_o, drive_out_a_o} <= out_nxt;
        end
    end

    // Checks
    ack_pulse_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
    static_level_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        !steer_act_r[0] |=> drive_out_a_o == $past(static_r[0]))
        else $error("unsteered output not static");
    disabled_idle_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        !en_r |=> !prim_r && comp_r) else $error("disabled drive wrong");
    fwd_hold_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        en_r && fb_mode && !fb_dir_r && steer_act_r[0] |=> drive_out_a_o)
        else $error("forward A not on");
    rev_hold_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        en_r && fb_mode && fb_dir_r && steer_act_r[2] |=> drive_out_c_o)
        else $error("reverse C not on");
    pp_pairs_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        en_r && mode_r == cpg_pkg::MD_PP && steer_act_r == 4'hf
        |=> drive_out_a_o == drive_out_c_o && drive_out_b_o == drive_out_d_o)
        else $error("push-pull pairs differ");
    rise_now_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        do_rise && rph_r == '0 && rdb_eff == '0 ##1 en_r |-> prim_r && !comp_r)
        else $error("primary not immediate");
    fall_blank_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        en_r && rblk_cnt_r != '0 && st_r == ST_ON |=> prim_r)
        else $error("falling input not blanked");
    sync_steer_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        mode_r == cpg_pkg::MD_SSTEER && !do_rise ##1 mode_r == cpg_pkg::MD_SSTEER
        |-> $stable(steer_act_r)) else $error("steering moved without rise");
    reserved_off_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        en_r && mode_r > cpg_pkg::MD_PP && steer_act_r == 4'hf
        |=> !drive_out_a_o && !drive_out_b_o && !drive_out_c_o && !drive_out_d_o)
        else $error("reserved mode drives");
endmodule

/* src/cpg_pkg.sv */
package cpg_pkg;
    // Register byte addresses on the bus
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STEER = 8'h04;
    localparam logic [7:0] ADR_RSRC = 8'h08;
    localparam logic [7:0] ADR_FSRC = 8'h0c;
    localparam logic [7:0] ADR_PHASE = 8'h10;
    localparam logic [7:0] ADR_DBAND = 8'h14;
    localparam logic [7:0] ADR_BLANK = 8'h18;
    localparam logic [7:0] ADR_STAT = 8'h1c;

    // Field positions; timing registers: rising value in lane 0, falling in lane 1; source registers: enable in lane 0, sense in lane 1
    localparam int CTRL_EN = 0;
    localparam int CTRL_MODE = 1;
    localparam int CTRL_CS = 4;
    localparam int STEER_EN = 0;
    localparam int STEER_LVL = 4;
    localparam int LANE0 = 0;
    localparam int LANE1 = 8;
    localparam int STAT_PRIM = 4;
    localparam int STAT_COMP = 5;
    localparam int STAT_DIR = 6;

    // Reset values
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [1:0] CS_RST = 2'h0;
    localparam logic [3:0] STEER_RST = 4'h0;

    // Operating mode codes
    localparam logic [2:0] MD_STEER = 3'h0;
    localparam logic [2:0] MD_SSTEER = 3'h1;
    localparam logic [2:0] MD_FWD = 3'h2;
    localparam logic [2:0] MD_REV = 3'h3;
    localparam logic [2:0] MD_HALF = 3'h4;
    localparam logic [2:0] MD_PP = 3'h5;

    // Complementary outputs B and D in half-bridge
    localparam logic [3:0] HB_COMP_MASK = 4'ha;

    // Timing clock selection codes
    localparam logic [1:0] CS_OSC = 2'h0;
    localparam logic [1:0] CS_INSN = 2'h1;
    localparam logic [1:0] CS_SYS = 2'h2;

    // Clock rates and derived dividers
    localparam int SYS_HZ = 100_000_000;
    localparam int OSC_HZ = 8_000_000;
    localparam int DIV_W = 4;
    localparam logic [DIV_W-1:0] OSC_DIV = DIV_W'(SYS_HZ / OSC_HZ);
    localparam logic [DIV_W-1:0] INSN_DIV = 4'h4;
endpackage

/* src/cpg_evt_cond.sv */
// Synchronises and qualifies event sources, then OR-combines them
module cpg_evt_cond #(
    parameter int N_SRC = 8
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Sources and their setup
    input wire logic [N_SRC-1:0] src_i,
    input wire logic [N_SRC-1:0] enable_i,
    input wire logic [N_SRC-1:0] sense_i,
    // Combined event level
    output logic comb_o
);
    logic [N_SRC-1:0] meta_r;
    logic [N_SRC-1:0] sync_r;
    logic [N_SRC-1:0] last_r;
    logic [N_SRC-1:0] hit;

    if (N_SRC < 1 || N_SRC > 8) begin : g_chk
        $error("N_SRC must lie in 1..8");
    end

    // Two-stage synchroniser; meta_r feeds only sync_r
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            meta_r <= '0;
            sync_r <= '0;
            last_r <= '0;
        end else begin
            meta_r <= src_i;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    // Edge sense gives a pulse, level sense passes the level
    for (genvar g = 0; g < N_SRC; g++) begin : g_src
        assign hit[g] = enable_i[g] & (sense_i[g] ? (sync_r[g] & ~last_r[g]) : sync_r[g]);
    end

    // Enabled sources are ORed into one event signal
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            comb_o <= 1'b0;
        end else begin
            comb_o <= |hit;
        end
    end
endmodule

/* dv/cpg_src_model.sv */
// Event source model: one PWM level on lane 0, complement on the fall side
module cpg_src_model (
    // Clock and wanted PWM level
    input wire logic mclk_i,
    input wire logic level_i,
    // Source buses towards the generator
    output logic [7:0] rise_o,
    output logic [7:0] fall_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [6:0] noise_r = 7'h00;
    logic [7:0] rise_r = 8'h00;
    logic [7:0] fall_r = 8'hff;

    // Unused lanes keep toggling so a disabled source must stay masked
    always_ff @(posedge mclk_i) begin
        noise_r <= noise_r + 7'h01;
        rise_r <= {noise_r, level_i};
        fall_r <= {noise_r, ~level_i};
    end
    assign rise_o = rise_r;
    assign fall_o = fall_r;
endmodule

/* dv/testbench.sv */
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic lvl = 1'b0;
    logic [7:0] rsrc;
    logic [7:0] fsrc;
    logic [3:0] outs;
    logic [3:0] p1;
    logic [31:0] q;
    int num_errors = 0;
    int tests_run = 0;
    logic [2:0] md [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h6};
    logic [3:0] hi [5] = '{4'hf, 4'h9, 4'h6, 4'h5, 4'h0};
    logic [3:0] lo [5] = '{4'h0, 4'h1, 4'h4, 4'ha, 4'h0};

    cpg_top #(.N_SRC(8), .TW(8)) dut (
        .mclk_i(mclk_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .rise_src_i(rsrc), .fall_src_i(fsrc), .drive_out_a_o(outs[0]),
        .drive_out_b_o(outs[1]), .drive_out_c_o(outs[2]), .drive_out_d_o(outs[3])
    );
    cpg_src_model src (.mclk_i(mclk_i), .level_i(lvl), .rise_o(rsrc), .fall_o(fsrc));

    // 100 MHz clock
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end

    task automatic finish_test();
        if (num_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One classic cycle; waits on ack, bounded by the watchdog
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge mclk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
    endtask

    // Set the PWM level and let the synchroniser and output stages settle
    task automatic drive(input logic v);
        @(posedge mclk_i);
        lvl <= v;
        repeat (12) @(posedge mclk_i);
    endtask

    task automatic set_mode(input logic [2:0] m);
        wb(1'b1, cpg_pkg::ADR_CTRL, (32'(cpg_pkg::CS_SYS) << 4) | (32'(m) << 1) | 32'h1);
    endtask

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge mclk_i);
        num_errors++;
        finish_test();
    end

    initial begin
        repeat (20) @(posedge mclk_i);
        reset_i <= 1'b0;
        wb(1'b0, cpg_pkg::ADR_CTRL, 32'h0);
        `CHK("ctrl", 32'h0, q)
        wb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped", 32'h0, q)
        wb(1'b1, cpg_pkg::ADR_STEER, 32'ha0);
        drive(1'b0);
        `CHK("static", 4'ha, outs)
        wb(1'b0, cpg_pkg::ADR_STAT, 32'h0);
        `CHK("status", 4'ha, q[3:0])
        wb(1'b1, cpg_pkg::ADR_RSRC, 32'h1);
        wb(1'b1, cpg_pkg::ADR_FSRC, 32'h1);
        wb(1'b1, cpg_pkg::ADR_STEER, 32'h0f);
        // Steered, forward, reverse, half-bridge and reserved mode 6: outputs with the PWM high, then low
        for (int i = 0; i < 5; i++) begin
            set_mode(md[i]);
            drive(1'b1);
            `CHK("mode_hi", hi[i], outs)
            drive(1'b0);
            `CHK("mode_lo", lo[i], outs)
        end
        // Synchronous steering waits for the next rising event
        wb(1'b1, cpg_pkg::ADR_STEER, 32'h03);
        set_mode(3'h1);
        drive(1'b1);
        wb(1'b1, cpg_pkg::ADR_STEER, 32'h0c);
        repeat (4) @(posedge mclk_i);
        `CHK("sync_hold", 4'h3, outs)
        drive(1'b0);
        drive(1'b1);
        `CHK("sync_new", 4'hc, outs)
        drive(1'b0);
        // Push-pull swaps pairs on successive periods
        wb(1'b1, cpg_pkg::ADR_STEER, 32'h0f);
        set_mode(3'h5);
        drive(1'b1);
        p1 = outs;
        `CHK("pp_pair", 1'b1, (p1 === 4'h5 || p1 === 4'ha))
        drive(1'b0);
        `CHK("pp_off", 4'h0, outs)
        drive(1'b1);
        `CHK("pp_swap", ~p1, outs)
        // Half bridge with phase delay, dead time and blanking; rise source edge sensed
        wb(1'b1, cpg_pkg::ADR_RSRC, 32'h101);
        wb(1'b1, cpg_pkg::ADR_PHASE, 32'h0002);
        wb(1'b1, cpg_pkg::ADR_DBAND, 32'h0206);
        wb(1'b1, cpg_pkg::ADR_BLANK, 32'h0020);
        wb(1'b0, cpg_pkg::ADR_PHASE, 32'h0);
        `CHK("phase", 32'h2, q)
        set_mode(cpg_pkg::MD_HALF);
        drive(1'b0);
        `CHK("hb_fall", 4'ha, outs)
        drive(1'b1);
        `CHK("hb_dead", 4'h0, outs)
        repeat (8) @(posedge mclk_i);
        `CHK("hb_rise", 4'h5, outs)
        // Fall inside the rising blank is lost; a later one is taken
        drive(1'b0);
        `CHK("hb_blank", 4'h5, outs)
        drive(1'b1);
        drive(1'b0);
        `CHK("hb_unblank", 4'ha, outs)
        finish_test();
    end
endmodule
